/* ies_selector.sv */
// interrupt event selector: slot routing, DMA sync decode and APB registers
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: sixteen slots, slot 0 highest priority
// RULE2: slots 0-3 fixed: reset, nmi, two reserved
// RULE3: slots 4-15 sourced by 5-bit selector fields
// RULE4: upper selector at 019C0000, lower at 019C0004
// RULE5: lower fields at 4:0..30:26, bits 15,31 empty
// RULE6: upper fields same layout for slots 10-15
// RULE7: reset slots 4-9: pins 4-7, dma 0-1
// RULE8: reset slots 10-15: sdram,dma2,dma3,host,t0,t1
// RULE9: interrupt selector code decode table
// RULE10: software avoids reserved selector codes
// RULE11: dma sync codes 01-0B timers, pins, dma
// RULE12: dma codes 0C-12 serial, host; others reserved
// RULE13: per-channel independent read and write sync
// RULE14: slot follows selected event; reserved means inactive
module ies_selector
  import ies_pkg::*;
#(
  parameter int SLOTS = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             reset_event,
  input  wire logic             nmi_event,
  input  wire ies_src_t         src,
  output logic      [SLOTS-1:0] cpu_slot,
  output logic      [3:0]       cpu_top_slot,
  output logic                  cpu_any,
  output ies_sync_t             dma_sync,
  output logic                  irq
);

  // the slot map is fixed: refuse any other count at elaboration
  if (SLOTS != IES_SLOTS) begin : g_slots_check
    $error("ies_selector: SLOTS must be 16");
  end

  // ==========================================================
  // event decoders
  // interrupt view: host at 00000, 10000 reserved
  function automatic logic int_event(input logic [4:0] code,
                                     input ies_src_t s);
    logic v;
    v = 1'b0;
    unique case (code)
      5'h00: v = s.host_interrupt; // RULE9
      5'h01: v = s.timer0_interrupt;
      5'h02: v = s.timer1_interrupt;
      5'h03: v = s.sdram_refresh_timer_interrupt;
      5'h04, 5'h05, 5'h06, 5'h07: v = s.external_pin_interrupt[code[1:0]];
      5'h08, 5'h09, 5'h0A, 5'h0B: v = s.dma_channel_done[code[1:0]];
      5'h0C: v = s.serial0_transmit_event;
      5'h0D: v = s.serial0_receive_event;
      5'h0E: v = s.serial1_transmit_event;
      5'h0F: v = s.serial1_receive_event;
      5'h11: v = s.serial2_transmit_event;
      5'h12: v = s.serial2_receive_event;
      default: v = 1'b0; // RULE14
    endcase
    return v;
  endfunction

  // dma view: host moves to 10000, 00000 reserved
  function automatic logic dma_event(input logic [4:0] code,
                                     input ies_src_t s);
    logic v;
    v = 1'b0;
    if (code == IES_CODE_DMAEVT_HOST) begin
      v = s.host_interrupt; // RULE12
    end else if (code != IES_CODE_HOST && code <= IES_CODE_LAST) begin
      v = int_event(code, s); // RULE11
    end
    return v;
  endfunction

  function automatic logic [4:0] field(input logic [31:0] r, input int i);
    logic [4:0] f;
    f = 5'h00;
    unique case (i)
      0: f = r[4:0]; // RULE5 RULE6
      1: f = r[9:5];
      2: f = r[14:10];
      3: f = r[20:16];
      4: f = r[25:21];
      default: f = r[30:26];
    endcase
    return f;
  endfunction

  // ==========================================================
  // source synchronisers: sources may come from other clocks or pins
  ies_src_t src_s1, src_s2;
  logic     rst_s1, rst_s2, nmi_s1, nmi_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_s1 <= '0;
      src_s2 <= '0;
      {rst_s1, rst_s2, nmi_s1, nmi_s2} <= 4'h0;
    end else begin
      src_s1 <= src;
      src_s2 <= src_s1;
      rst_s1 <= reset_event;
      rst_s2 <= rst_s1;
      nmi_s1 <= nmi_event;
      nmi_s2 <= nmi_s1;
    end
  end

  // ==========================================================
  // registers
  logic [31:0] upper_slot_source_select, next_upper;
  logic [31:0] lower_slot_source_select, next_lower;
  // eight 5-bit codes do not fit one word: channels 2-3 sit in the high word
  logic [63:0] dma_sync_select, next_dma_sync;
  logic [3:0]  irq_status, next_status;
  logic [3:0]  irq_enable, next_enable;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        bad_code, next_bad;
  logic [3:0]  ev;

  wire setup  = psel && !penable;
  wire access = psel && penable;
  wire wr     = access && pwrite;

  // ==========================================================
  // routing
  logic [SLOTS-1:0] next_slot;
  logic [3:0]       next_top;
  logic             next_any;
  ies_sync_t        next_sync;
  logic [4:0]       code;

  always_comb begin
    next_slot = '0;
    next_slot[0] = rst_s2; // RULE2
    next_slot[1] = nmi_s2;
    for (int i = 0; i < IES_FIELDS; i++) begin
      // new selector applies from the cycle after the write completes
      next_slot[IES_FIRST_PROG + i] =
        int_event(field(lower_slot_source_select, i), src_s2); // RULE3 RULE14
      next_slot[IES_FIRST_PROG + IES_FIELDS + i] =
        int_event(field(upper_slot_source_select, i), src_s2);
    end
    next_top = 4'h0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (next_slot[i]) next_top = 4'(i); // RULE1
    end
    next_any = |next_slot;
    next_sync = '0;
    for (int c = 0; c < IES_DMA_CH; c++) begin
      code = dma_sync_select[c*16 +: 5];
      next_sync.read_sync[c] = dma_event(code, src_s2); // RULE13
      code = dma_sync_select[c*16 + 8 +: 5];
      next_sync.write_sync[c] = dma_event(code, src_s2);
    end
    code = 5'h00;
  end

  // ==========================================================
  // apb slave: zero wait, unmapped addresses answer pslverr
  always_comb begin
    next_upper    = upper_slot_source_select;
    next_lower    = lower_slot_source_select;
    next_dma_sync = dma_sync_select;
    next_enable   = irq_enable;
    next_prdata   = 32'h0000_0000;
    next_pslverr  = 1'b0;
    next_bad      = 1'b0;
    ev            = 4'h0;
    if (wr) begin
      unique case (paddr)
        IES_UPPER_ADDR: next_upper = pwdata & IES_SEL_MASK; // RULE4
        IES_LOWER_ADDR: next_lower = pwdata & IES_SEL_MASK;
        IES_DMA_SYNC_ADDR: next_dma_sync[31:0] = pwdata & IES_SYNC_MASK;
        IES_DMA_SYNC_HI_ADDR:
          next_dma_sync[63:32] = pwdata & IES_SYNC_MASK; // RULE13
        IES_IRQ_EN_ADDR: next_enable = pwdata[3:0];
        default: ;
      endcase
      // reserved code written: flagged, still routes nothing
      if (paddr == IES_UPPER_ADDR || paddr == IES_LOWER_ADDR) begin
        for (int i = 0; i < IES_FIELDS; i++) begin
          if (field(pwdata, i) > IES_CODE_LAST ||
              field(pwdata, i) == IES_CODE_DMAEVT_HOST) begin
            next_bad = 1'b1; // RULE10
          end
        end
      end
    end
    if (setup) begin
      unique case (paddr)
        IES_UPPER_ADDR: next_prdata = upper_slot_source_select;
        IES_LOWER_ADDR: next_prdata = lower_slot_source_select;
        IES_DMA_SYNC_ADDR: next_prdata = dma_sync_select[31:0];
        IES_DMA_SYNC_HI_ADDR: next_prdata = dma_sync_select[63:32];
        IES_IRQ_STAT_ADDR: next_prdata = {28'h0000000, irq_status};
        IES_IRQ_EN_ADDR: next_prdata = {28'h0000000, irq_enable};
        IES_IRQ_CLR_ADDR: next_prdata = 32'h0000_0000;
        default: next_pslverr = 1'b1;
      endcase
    end
    // events: reset seen, nmi seen, reserved-code write, any maskable slot
    ev[0] = rst_s2;
    ev[1] = nmi_s2;
    ev[2] = bad_code;
    ev[3] = |cpu_slot[SLOTS-1:IES_FIRST_PROG];
    next_status = irq_status;
    if (wr && paddr == IES_IRQ_CLR_ADDR) next_status = irq_status & ~pwdata[3:0];
    next_status = next_status | ev; // set wins over clear
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_slot_source_select <= IES_UPPER_RESET; // RULE8
      lower_slot_source_select <= IES_LOWER_RESET; // RULE7
      dma_sync_select <= {IES_DMA_SYNC_RESET, IES_DMA_SYNC_RESET};
      irq_status <= 4'h0;
      irq_enable <= IES_IRQ_EN_RESET;
      bad_code   <= 1'b0;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      cpu_slot   <= '0;
      cpu_top_slot <= 4'h0;
      cpu_any    <= 1'b0;
      dma_sync   <= '0;
      irq        <= 1'b0;
    end else begin
      upper_slot_source_select <= next_upper;
      lower_slot_source_select <= next_lower;
      dma_sync_select <= next_dma_sync;
      irq_status <= next_status;
      irq_enable <= next_enable;
      bad_code   <= next_bad;
      if (setup) begin
        prdata  <= next_prdata;
        pslverr <= next_pslverr;
      end
      pready     <= setup;
      cpu_slot   <= next_slot;
      cpu_top_slot <= next_top;
      cpu_any    <= next_any;
      dma_sync   <= next_sync;
      irq        <= |(next_status & next_enable);
    end
  end

  // ==========================================================
  // checks
  a_fixed_reserved: assert property ( // RULE2
    @(posedge pclk) disable iff (!presetn)
    cpu_slot[3:2] == 2'b00) else $error("reserved slot active");
  a_upper_addr: assert property ( // RULE4
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == IES_UPPER_ADDR |=> upper_slot_source_select ==
    ($past(pwdata) & IES_SEL_MASK)) else $error("upper write lost");
  a_lower_addr: assert property ( // RULE4
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == IES_LOWER_ADDR |=> lower_slot_source_select ==
    ($past(pwdata) & IES_SEL_MASK)) else $error("lower write lost");
  a_unused_bits: assert property ( // RULE5 RULE6
    @(posedge pclk) disable iff (!presetn)
    (upper_slot_source_select & ~IES_SEL_MASK) == 32'h0000_0000 &&
    (lower_slot_source_select & ~IES_SEL_MASK) == 32'h0000_0000)
    else $error("unused bit set");
  // a slot shows the selector and sources of the cycle before
  a_slot4_route: assert property ( // RULE3
    @(posedge pclk) disable iff (!presetn)
    ##1 cpu_slot[4] ==
    int_event($past(lower_slot_source_select[4:0]), $past(src_s2)))
    else $error("slot 4 route wrong");
  a_slot15_route: assert property ( // RULE6
    @(posedge pclk) disable iff (!presetn)
    ##1 cpu_slot[15] ==
    int_event($past(upper_slot_source_select[30:26]), $past(src_s2)))
    else $error("slot 15 route wrong");
  a_reserved_idle: assert property ( // RULE14
    @(posedge pclk) disable iff (!presetn)
    lower_slot_source_select[9:5] > 5'h12 ##1
    $stable(lower_slot_source_select) |-> !cpu_slot[5])
    else $error("reserved code drives slot");
  a_top_priority: assert property ( // RULE1
    @(posedge pclk) disable iff (!presetn)
    cpu_slot[0] |-> cpu_top_slot == 4'h0 && cpu_any)
    else $error("slot 0 not top");
  a_top_lower: assert property ( // RULE1
    @(posedge pclk) disable iff (!presetn)
    cpu_any |-> cpu_slot[cpu_top_slot] &&
    ((cpu_slot & ((16'h0001 << cpu_top_slot) - 16'h0001)) == 16'h0000))
    else $error("priority order wrong");
  a_dma_host: assert property ( // RULE12
    @(posedge pclk) disable iff (!presetn)
    dma_sync_select[4:0] == 5'h00 ##1 $stable(dma_sync_select)
    |-> !dma_sync.read_sync[0]) else $error("dma code 0 fires");
  a_dma_timer: assert property ( // RULE11 RULE13
    @(posedge pclk) disable iff (!presetn)
    dma_sync_select[12:8] == 5'h01 ##1 $stable(dma_sync_select)
    |-> dma_sync.write_sync[0] == $past(src_s2.timer0_interrupt))
    else $error("dma timer sync wrong");
  a_dma_hi_write: assert property ( // RULE13
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == IES_DMA_SYNC_HI_ADDR |=> dma_sync_select[63:32] ==
    ($past(pwdata) & IES_SYNC_MASK)) else $error("high sync write lost");
  a_nmi_sticky: assert property ( // RULE2
    @(posedge pclk) disable iff (!presetn)
    nmi_s2 |=> irq_status[1]) else $error("nmi not recorded");
  a_pready_pulse: assert property ( // RULE4
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready) else $error("pready not one cycle");
  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 irq == |(irq_status & irq_enable)) else $error("irq level wrong");

endmodule

/* ies_pkg.sv */
// package: offsets, field layout, event codes and reset values for the selector
package ies_pkg;

  // ==========================================================
  // register map
  localparam logic [31:0] IES_UPPER_ADDR   = 32'h019C_0000;
  localparam logic [31:0] IES_LOWER_ADDR   = 32'h019C_0004;
  localparam logic [31:0] IES_DMA_SYNC_ADDR = 32'h019C_0008;
  localparam logic [31:0] IES_IRQ_STAT_ADDR = 32'h019C_000C;
  localparam logic [31:0] IES_IRQ_CLR_ADDR  = 32'h019C_0010;
  localparam logic [31:0] IES_IRQ_EN_ADDR   = 32'h019C_0014;
  localparam logic [31:0] IES_DMA_SYNC_HI_ADDR = 32'h019C_0018;

  // ==========================================================
  // field layout: six 5-bit fields per selector, bits 15 and 31 unused
  localparam int IES_FIELD_W   = 5;
  localparam int IES_FIELDS    = 6;
  localparam int IES_SLOTS     = 16;
  localparam int IES_FIRST_PROG = 4;
  localparam int IES_DMA_CH    = 4;
  localparam logic [31:0] IES_SEL_MASK = 32'h7FFF_7FFF;
  localparam logic [31:0] IES_SYNC_MASK = 32'h1F1F_1F1F;
  localparam logic [31:0] IES_UPPER_RESET = 32'h0820_2D43;
  localparam logic [31:0] IES_LOWER_RESET = 32'h2507_18A4;
  localparam logic [31:0] IES_DMA_SYNC_RESET = 32'h0000_0000;
  localparam logic [3:0]  IES_IRQ_EN_RESET = 4'h0;

  // ==========================================================
  // 5-bit event codes (interrupt selector view, plus the dma view host code)
  localparam logic [4:0] IES_CODE_HOST   = 5'h00;
  localparam logic [4:0] IES_CODE_DMAEVT_HOST = 5'h10;
  localparam logic [4:0] IES_CODE_LAST   = 5'h12;

  // event sources from peripherals
  typedef struct packed {
    logic       serial2_receive_event;
    logic       serial2_transmit_event;
    logic       host_interrupt;
    logic       serial1_receive_event;
    logic       serial1_transmit_event;
    logic       serial0_receive_event;
    logic       serial0_transmit_event;
    logic [3:0] dma_channel_done;
    logic [3:0] external_pin_interrupt;
    logic       sdram_refresh_timer_interrupt;
    logic       timer1_interrupt;
    logic       timer0_interrupt;
  } ies_src_t;

  // per-channel DMA sync strobes
  typedef struct packed {
    logic [3:0] read_sync;
    logic [3:0] write_sync;
  } ies_sync_t;

endpackage

/* ies_src_model.sv */
// peripheral side model: holds each event source as a steady level
`timescale 1ns/1ps
module ies_src_model
  import ies_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire ies_src_t want,
  output ies_src_t      src
);
  // ==========================================================
  // levels move only after an edge, never mid-cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src <= '0;
    end else begin
      src <= want;
    end
  end
endmodule

/* ies_selector_tb.sv */
// testbench: selector compared with an integer model of the code tables
`timescale 1ns/1ps
module ies_selector_tb;
  import ies_pkg::*;
  localparam int SW = $bits(ies_src_t);
  logic        pclk, presetn, psel, penable, pwrite;
  logic        reset_event, nmi_event, pready, pslverr, irq, er;
  logic [31:0] paddr, pwdata, prdata, rd, w;
  logic [15:0] cpu_slot;
  logic [3:0]  cpu_top_slot;
  logic        cpu_any;
  ies_src_t    want, src;
  ies_sync_t   dma_sync;
  int          n_mismatch, n_checks, code[16], dcode[8];
  int          bad;
  int          pos[6] = '{0, 5, 10, 16, 21, 26};

  ies_selector ies_selector_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_event(reset_event),
    .nmi_event(nmi_event), .src(src), .cpu_slot(cpu_slot),
    .cpu_top_slot(cpu_top_slot), .cpu_any(cpu_any),
    .dma_sync(dma_sync), .irq(irq));
  ies_src_model ies_src_model_inst (.pclk(pclk), .presetn(presetn),
    .want(want), .src(src));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ==========================================================
  // model and helpers
  function automatic logic hit(int c, ies_src_t s, bit dma);
    case (c)
      0: return dma ? 1'b0 : s.host_interrupt;
      1: return s.timer0_interrupt;
      2: return s.timer1_interrupt;
      3: return s.sdram_refresh_timer_interrupt;
      4, 5, 6, 7: return s.external_pin_interrupt[c-4];
      8, 9, 10, 11: return s.dma_channel_done[c-8];
      12: return s.serial0_transmit_event;
      13: return s.serial0_receive_event;
      14: return s.serial1_transmit_event;
      15: return s.serial1_receive_event;
      16: return dma ? s.host_interrupt : 1'b0;
      17: return s.serial2_transmit_event;
      18: return s.serial2_receive_event;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] pack(int base);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < 6; i++) v |= 32'(code[base+i] & 31) << pos[i];
    return v;
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(logic wr, logic [31:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic check_out();
    logic [15:0] e;
    logic [7:0]  ds;
    int          t;
    e = '0; e[0] = reset_event; e[1] = nmi_event; t = 0;
    for (int k = 4; k < 16; k++) e[k] = hit(code[k], src, 0);
    for (int k = 15; k >= 0; k--) if (e[k]) t = k;
    for (int c = 0; c < 4; c++) begin
      ds[4+c] = hit(dcode[c], src, 1);
      ds[c] = hit(dcode[4+c], src, 1);
    end
    chk("cpu_slot", 32'(cpu_slot), 32'(e));
    chk("cpu_top_slot", 32'(cpu_top_slot), 32'(t));
    chk("cpu_any", 32'(cpu_any), 32'(e != 0));
    chk("dma_sync", 32'(dma_sync), 32'(ds));
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #750000;
    n_mismatch++;
    end_sim();
  end

  // ==========================================================
  // tests
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    reset_event = 0; nmi_event = 0; want = '0; presetn = 0;
    code = '{0, 0, 0, 0, 4, 5, 6, 7, 8, 9, 3, 10, 11, 0, 1, 2};
    dcode = '{default: 0};
    bad = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    w = $urandom(38);
    apb(0, IES_LOWER_ADDR, '0);
    chk("lower_reset", rd, pack(4));
    apb(0, IES_UPPER_ADDR, '0);
    chk("upper_reset", rd, pack(10));
    $display("test reset values done");
    // one source at a time, default routing
    for (int i = 0; i < SW; i++) begin
      w = '0;
      w[i] = 1'b1;
      want <= w[SW-1:0];
      repeat (5) @(posedge pclk);
      check_out();
    end
    $display("test default routing done");
    // random codes, reserved ones included on purpose
    for (int n = 0; n < 40; n++) begin
      for (int k = 4; k < 16; k++) code[k] = $urandom_range(0, 31);
      for (int c = 0; c < 8; c++) dcode[c] = $urandom_range(0, 31);
      // first pass ties channel 0 write sync to timer 0
      if (n == 0) dcode[4] = 1;
      for (int k = 4; k < 16; k++) if (code[k] == 16 || code[k] > 18) bad = 1;
      apb(1, IES_LOWER_ADDR, pack(4));
      apb(1, IES_UPPER_ADDR, pack(10));
      // channels 0-1 in the low sync word, 2-3 in the high one
      for (int h = 0; h < 2; h++) begin
        w = '0;
        for (int c = 2*h; c < 2*h+2; c++)
          w |= (32'(dcode[c]) << ((c%2)*16)) |
               (32'(dcode[4+c]) << ((c%2)*16+8));
        apb(1, h ? IES_DMA_SYNC_HI_ADDR : IES_DMA_SYNC_ADDR, w);
        apb(0, h ? IES_DMA_SYNC_HI_ADDR : IES_DMA_SYNC_ADDR, '0);
        chk("dma_sync_rb", rd, w);
      end
      apb(0, IES_LOWER_ADDR, '0);
      chk("lower_rb", rd, pack(4) & IES_SEL_MASK);
      apb(0, IES_UPPER_ADDR, '0);
      chk("upper_rb", rd, pack(10) & IES_SEL_MASK);
      w = $urandom;
      want <= w[SW-1:0];
      reset_event <= w[30];
      nmi_event <= w[31];
      repeat (5) @(posedge pclk);
      check_out();
    end
    apb(0, IES_IRQ_STAT_ADDR, '0);
    chk("status_bad_code", 32'(rd[2]), 32'(bad));
    $display("test random routing done");
    apb(1, 32'h019C_0020, 32'hFFFF_FFFF);
    chk("unmapped_wr_err", 32'(er), 32'h1);
    apb(0, 32'h019C_0020, '0);
    chk("unmapped_rd", rd, 32'h0);
    $display("test unmapped done");
    // interrupt: clear, raise, mask, unmask, clear
    want <= '0; reset_event <= 0; nmi_event <= 0;
    repeat (5) @(posedge pclk);
    apb(1, IES_IRQ_EN_ADDR, 32'h0);
    apb(1, IES_IRQ_CLR_ADDR, 32'hF);
    apb(0, IES_IRQ_STAT_ADDR, '0);
    chk("status_clear", rd, 32'h0);
    nmi_event <= 1'b1;
    repeat (5) @(posedge pclk);
    nmi_event <= 1'b0;
    apb(1, IES_IRQ_STAT_ADDR, 32'h0); // status is read-only
    apb(0, IES_IRQ_STAT_ADDR, '0);
    chk("status_nmi", rd, 32'h2);
    chk("irq_masked", 32'(irq), 32'h0);
    apb(1, IES_IRQ_EN_ADDR, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq_on", 32'(irq), 32'h1);
    apb(1, IES_IRQ_CLR_ADDR, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq_cleared", 32'(irq), 32'h0);
    apb(0, IES_IRQ_STAT_ADDR, '0);
    chk("status_after_clr", rd, 32'h0);
    $display("test interrupt done");
    end_sim();
  end
endmodule
